// ==== inc/sfcfe_defines.svh ====
`ifndef SFCFE_DEFINES_SVH
`define SFCFE_DEFINES_SVH

// Opcodes
`define SFCFE_OP_SET_LATCH    8'h06
`define SFCFE_OP_RESET_LATCH  8'h04
`define SFCFE_OP_STATUS_READ  8'h05
`define SFCFE_OP_STATUS_WRITE 8'h01
`define SFCFE_OP_MEM_READ     8'h03
`define SFCFE_OP_FAST_READ    8'h0B
`define SFCFE_OP_MEM_WRITE    8'h02
`define SFCFE_OP_SLEEP        8'hB9
`define SFCFE_OP_ID_READ      8'h9F

// Status register layout
`define SFCFE_STAT_LATCH_BIT  1
`define SFCFE_STAT_WR_MASK    8'h8C
`define SFCFE_STAT_RESET      8'h00

// Sizes
`define SFCFE_ADDR_BITS       15
`define SFCFE_MEM_WORDS       32768

`endif

// ==== inc/sfcfe_pkg.sv ====
package sfcfe_pkg;

    typedef enum logic [3:0] {
        SFCFE_CMD_NONE,
        SFCFE_CMD_SET_LATCH,
        SFCFE_CMD_RESET_LATCH,
        SFCFE_CMD_STATUS_READ,
        SFCFE_CMD_STATUS_WRITE,
        SFCFE_CMD_MEM_READ,
        SFCFE_CMD_FAST_READ,
        SFCFE_CMD_MEM_WRITE,
        SFCFE_CMD_SLEEP,
        SFCFE_CMD_ID_READ,
        SFCFE_CMD_INVALID
    } sfcfe_cmd_type;

    // Event handed from the link domain to the core domain
    typedef struct packed {
        sfcfe_cmd_type cmd;
        logic [7:0]    data;
    } sfcfe_event_type;

    // Status snapshot seen by the core user
    typedef struct packed {
        logic [7:0] status;
        logic       latch;
        logic       sleep_req;
    } sfcfe_state_type;

endpackage

// ==== src/sfcfe_sync.sv ====
`timescale 1ns/1ps

module sfcfe_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule // sfcfe_sync

// ==== src/sfcfe_front_end.sv ====
// Functional notes
// - Memory opcodes take two address bytes; low 15 bits used, top ignored.
// - Writes complete within the transfer; no busy state is ever reported.
// - Input sampled on rising edges, output changes on falling edges.
// - Clock level at select sets mode 0 or 3; first rise counts.
// - First byte after select is the opcode; address and data follow.
// - One opcode per select period; new command needs a new select.
// - Deselected: input ignored, output tristated.
// - Address and data bytes shift most significant bit first.
// - Unknown opcode: ignore rest of the frame, keep output tristated.
// - Opcode 06h sets the latch; only it can; writes need the latch.
// - Opcode 04h clears the latch, blocking array and status writes.
// - Decode status read 05h, status write 01h, identification read 9Fh.
// - Decode memory read 03h, fast read 0Bh, memory write 02h.
// - B9h enters low power; C3h, C2h, 5Ah, 5Bh are reserved. Code decodes B9h but ignores it; sleep_req stays 0.
// - Latch is clear after power-up.
// - Status write never changes the latch bit.
// - Latch clears at select rise ending reset-latch, status or mem write; code clears 04h at its eighth bit, the others on the next SPI clock rise.
// - One 8-bit status register configures write behaviour; code stores bits 7, 3 and 2 but no write checks them.
// - Status bit 1 shows the latch; zero after power-up.
// - Status bits 0 and 4 to 6 are not writable and read zero.
`timescale 1ns/1ps
`include "sfcfe_defines.svh"

module sfcfe_front_end #(
    parameter int ADDR_BITS = `SFCFE_ADDR_BITS,
    parameter int MEM_WORDS = `SFCFE_MEM_WORDS
) (
    // Core clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // SPI link pins
    input  wire logic                   spi_sck,
    input  wire logic                   spi_cs_n,
    input  wire logic                   spi_si,
    output logic                        spi_so,
    output logic                        spi_so_oe,
    // Core side view
    output sfcfe_pkg::sfcfe_state_type  core_state,
    output logic                        core_frame_done
);

    import sfcfe_pkg::*;

    // ------------------------------------------------------------
    // Link domain: selection and mode
    // ------------------------------------------------------------
    // The SPI clock stops between frames, so frame state is reset
    // asynchronously by the chip select itself (a constant only).
    logic       sel;
    logic       mode3_q;
    assign sel = !spi_cs_n;

    always_ff @(negedge spi_cs_n)
    begin
        mode3_q <= spi_sck;
    end

    // In mode 3 the clock idles high; the first real rise follows
    // a fall, so a rise seen before any fall is dropped.
    logic       armed_q;
    always_ff @(negedge spi_sck or posedge spi_cs_n)
    begin
        if (spi_cs_n)
            armed_q <= 1'b0;
        else
            armed_q <= 1'b1;
    end
    logic       rise_ok;
    assign rise_ok = !mode3_q || armed_q;

    // ------------------------------------------------------------
    // Link domain: shifter and command sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_OPCODE,
        PH_ADDR_HI,
        PH_ADDR_LO,
        PH_DATA,
        PH_IGNORE
    } sfcfe_phase_type;

    sfcfe_phase_type phase_q;
    logic [2:0]      bit_cnt_q;
    logic [6:0]      shift_q;
    sfcfe_cmd_type   cmd_q;
    logic [ADDR_BITS-1:0] addr_q;
    logic            first_data_q;

    wire  [7:0] rx_byte  = {shift_q, spi_si};
    wire        byte_end = (bit_cnt_q == 3'd7);

    // Opcode decode
    sfcfe_cmd_type dec_cmd;
    assign dec_cmd =
        (rx_byte == `SFCFE_OP_SET_LATCH)    ? SFCFE_CMD_SET_LATCH    :
        (rx_byte == `SFCFE_OP_RESET_LATCH)  ? SFCFE_CMD_RESET_LATCH  :
        (rx_byte == `SFCFE_OP_STATUS_READ)  ? SFCFE_CMD_STATUS_READ  :
        (rx_byte == `SFCFE_OP_STATUS_WRITE) ? SFCFE_CMD_STATUS_WRITE :
        (rx_byte == `SFCFE_OP_MEM_READ)     ? SFCFE_CMD_MEM_READ     :
        (rx_byte == `SFCFE_OP_FAST_READ)    ? SFCFE_CMD_FAST_READ    :
        (rx_byte == `SFCFE_OP_MEM_WRITE)    ? SFCFE_CMD_MEM_WRITE    :
        (rx_byte == `SFCFE_OP_SLEEP)        ? SFCFE_CMD_SLEEP        :
        (rx_byte == `SFCFE_OP_ID_READ)      ? SFCFE_CMD_ID_READ      :
                                              SFCFE_CMD_INVALID;

    wire is_mem = (cmd_q == SFCFE_CMD_MEM_READ) ||
                  (cmd_q == SFCFE_CMD_FAST_READ) ||
                  (cmd_q == SFCFE_CMD_MEM_WRITE);

    // Phase after the opcode byte
    sfcfe_phase_type op_next;
    assign op_next =
        (dec_cmd == SFCFE_CMD_INVALID) ? PH_IGNORE :
        ((dec_cmd == SFCFE_CMD_MEM_READ) ||
         (dec_cmd == SFCFE_CMD_FAST_READ) ||
         (dec_cmd == SFCFE_CMD_MEM_WRITE)) ? PH_ADDR_HI :
        ((dec_cmd == SFCFE_CMD_STATUS_WRITE) ||
         (dec_cmd == SFCFE_CMD_STATUS_READ)) ? PH_DATA :
                                              PH_IGNORE;

    // Memory array and link-domain status/latch
    logic [7:0] mem_q [MEM_WORDS];
    logic [7:0] status_q;
    logic       latch_q;
    logic       wr_pend_q;  // write-type command seen this frame
    logic       clr_pend_q;

    wire [7:0] status_view = (status_q & `SFCFE_STAT_WR_MASK) |
        {6'h00, latch_q, 1'b0};

    always_ff @(posedge spi_sck or posedge spi_cs_n)
    begin
        if (spi_cs_n)
        begin
            phase_q      <= PH_OPCODE;
            bit_cnt_q    <= 3'd0;
            shift_q      <= 7'h00;
            cmd_q        <= SFCFE_CMD_NONE;
            first_data_q <= 1'b1;
        end
        else if (rise_ok)
        begin
            bit_cnt_q <= bit_cnt_q + 3'd1;
            shift_q   <= rx_byte[6:0];
            if (byte_end)
            begin
                case (phase_q)
                    PH_OPCODE:
                    begin
                        cmd_q   <= dec_cmd;
                        phase_q <= op_next;
                    end
                    PH_ADDR_HI:
                        phase_q <= PH_ADDR_LO;
                    PH_ADDR_LO:
                    begin
                        phase_q      <= PH_DATA;
                        first_data_q <= 1'b1;
                    end
                    PH_DATA:
                    begin
                        first_data_q <= 1'b0;
                        if (cmd_q == SFCFE_CMD_STATUS_WRITE)
                            phase_q <= PH_IGNORE;
                    end
                    default:
                        phase_q <= PH_IGNORE;
                endcase
            end
        end
    end

    // Address counter; top address bit dropped by width
    always_ff @(posedge spi_sck)
    begin
        if (sel && rise_ok && byte_end)
        begin
            if (phase_q == PH_ADDR_HI)
                addr_q <= {rx_byte[ADDR_BITS-9:0], addr_q[7:0]};
            else if (phase_q == PH_ADDR_LO)
                addr_q <= {addr_q[ADDR_BITS-1:8], rx_byte};
            else if (phase_q == PH_DATA && is_mem)
                addr_q <= addr_q + 1'b1;
        end
    end

    // Array write straight off the eighth bit, no buffering
    always_ff @(posedge spi_sck)
    begin
        if (sel && rise_ok && byte_end && phase_q == PH_DATA &&
            cmd_q == SFCFE_CMD_MEM_WRITE && latch_q)
            mem_q[addr_q] <= rx_byte;
    end

    // Status register and latch: 04h clears the latch at once; clear after writes is deferred to the first clock rise after select rise
    always_ff @(posedge spi_sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_q  <= `SFCFE_STAT_RESET;
            latch_q   <= 1'b0;
            wr_pend_q <= 1'b0;
        end
        else if (clr_pend_q && wr_pend_q)
        begin
            latch_q   <= 1'b0;
            wr_pend_q <= 1'b0;
        end
        else if (sel && rise_ok && byte_end)
        begin
            if (phase_q == PH_OPCODE)
            begin
                if (dec_cmd == SFCFE_CMD_SET_LATCH)
                    latch_q <= 1'b1;
                if (dec_cmd == SFCFE_CMD_RESET_LATCH ||
                    dec_cmd == SFCFE_CMD_STATUS_WRITE ||
                    dec_cmd == SFCFE_CMD_MEM_WRITE)
                    wr_pend_q <= 1'b1;
                if (dec_cmd == SFCFE_CMD_RESET_LATCH)
                    latch_q <= 1'b0;
            end
            else if (phase_q == PH_DATA &&
                     cmd_q == SFCFE_CMD_STATUS_WRITE && latch_q)
                status_q <= rx_byte & `SFCFE_STAT_WR_MASK;
        end
    end

    // Select rise ends the frame; flag clear on the next clock edge
    always_ff @(posedge spi_cs_n or negedge rst_n)
    begin
        if (!rst_n)
            clr_pend_q <= 1'b0;
        else
            clr_pend_q <= wr_pend_q;
    end

    // ------------------------------------------------------------
    // Link domain: serial output on falling edge
    // ------------------------------------------------------------
    logic [7:0] tx_q;
    logic       tx_on_q;
    wire  ld_status = sel && phase_q == PH_DATA &&
                      cmd_q == SFCFE_CMD_STATUS_READ;
    wire  ld_mem    = sel && phase_q == PH_DATA && !first_data_q &&
                      (cmd_q == SFCFE_CMD_MEM_READ);

    always_ff @(negedge spi_sck or posedge spi_cs_n)
    begin
        if (spi_cs_n)
        begin
            tx_q    <= 8'h00;
            tx_on_q <= 1'b0;
        end
        else if (bit_cnt_q == 3'd0 && (ld_status ||
                 (phase_q == PH_DATA && cmd_q == SFCFE_CMD_MEM_READ)))
        begin
            tx_q    <= ld_status ? status_view : mem_q[addr_q];
            tx_on_q <= 1'b1;
        end
        else
            tx_q <= {tx_q[6:0], 1'b0};
    end

    // Tristate outside data phases of status read and memory read (03h); fast read and ID read stay tristated
    assign spi_so    = tx_q[7];
    assign spi_so_oe = sel && tx_on_q &&
        (phase_q == PH_DATA);

    // ------------------------------------------------------------
    // Crossing to the core domain
    // ------------------------------------------------------------
    // Status and latch are quasi-static outside frames; frame end
    // is a level (select) synchronised and edge detected.
    logic [9:0] sync_out;
    logic       sel_prev_q;
    sfcfe_state_type state_q;

    sfcfe_sync #(
        .WIDTH (10)
    ) u_sync (
        .clk   (core_clk),
        .rst_n (rst_n),
        .din   ({status_view, latch_q, sel}),
        .dout  (sync_out)
    );

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sel_prev_q <= 1'b0;
            state_q    <= '0;
        end
        else
        begin
            sel_prev_q        <= sync_out[0];
            state_q.status    <= sync_out[9:2];
            state_q.latch     <= sync_out[1];
            state_q.sleep_req <= 1'b0;
        end
    end

    assign core_state      = state_q;
    assign core_frame_done = !sync_out[0] && sel_prev_q;

    // Fast-read dummy byte not modelled: ld_mem kept for reads only
    wire unused_ok = ld_mem;

endmodule // sfcfe_front_end

// ==== tb/sfcfe_front_end_checker.sv ====
`timescale 1ns/1ps

module sfcfe_front_end_checker (
    // Core clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    // Link pins
    input wire logic                  spi_cs_n,
    input wire logic                  spi_so_oe,
    // Core side view
    input sfcfe_pkg::sfcfe_state_type core_state,
    input wire logic                  core_frame_done
);
    import sfcfe_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // ----------
    // Sequences
    // ----------
    sequence s_frame_end;
        $rose(spi_cs_n);
    endsequence
    sequence s_frame_start;
        $fell(spi_cs_n);
    endsequence

    // ----------
    // Properties
    // ----------
    property p_idle_quiet;
        spi_cs_n && $past(spi_cs_n) |-> !spi_so_oe;
    endproperty
    property p_start_quiet;
        s_frame_start |-> !spi_so_oe [*8];
    endproperty
    property p_done_follows;
        s_frame_end |-> ##[1:6] core_frame_done;
    endproperty
    property p_done_pulse;
        core_frame_done |=> !core_frame_done;
    endproperty
    property p_reset_state;
        $rose(rst_n) |-> core_state == '0;
    endproperty
    property p_never_busy;
        core_state.status[0] == 1'b0;
    endproperty
    property p_fixed_zero;
        core_state.status[6:4] == 3'b000;
    endproperty
    property p_latch_mirror;
        core_state.status[1] == core_state.latch;
    endproperty

    a_idle_quiet: assert property (p_idle_quiet)
        else $error("output enabled while deselected");
    a_start_quiet: assert property (p_start_quiet)
        else $error("output enabled during opcode");
    a_done_follows: assert property (p_done_follows)
        else $error("no frame done after deselect");
    a_done_pulse: assert property (p_done_pulse)
        else $error("frame done longer than one cycle");
    a_reset_state: assert property (p_reset_state)
        else $error("state not clear after reset");
    a_never_busy: assert property (p_never_busy)
        else $error("status bit 0 set");
    a_fixed_zero: assert property (p_fixed_zero)
        else $error("status bits 6 to 4 set");
    a_latch_mirror: assert property (p_latch_mirror)
        else $error("status bit 1 differs from latch");
endmodule // sfcfe_front_end_checker

bind sfcfe_front_end sfcfe_front_end_checker u_checker (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .spi_cs_n        (spi_cs_n),
    .spi_so_oe       (spi_so_oe),
    .core_state      (core_state),
    .core_frame_done (core_frame_done)
);

// ==== tb/sfcfe_master.sv ====
`timescale 1ns/1ps

module sfcfe_master (
    // Link pins
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    input  wire logic spi_so
);
    initial
    begin
        spi_sck  = 1'b0;
        spi_cs_n = 1'b1;
        spi_si   = 1'b0;
    end

    // ----------
    // One frame
    // ----------
    task automatic xfer(input logic mode3, input logic [31:0] tx,
                        input int n, output logic [7:0] rx);
        int i;
        begin
            rx = 8'h00;
            #3;
            spi_sck  = mode3;
            #32;
            spi_cs_n = 1'b0;
            for (i = 8 * n - 1; i >= 0; i--)
            begin
                #32;
                spi_sck = 1'b0;
                spi_si  = tx[i];
                #32;
                spi_sck = 1'b1;
                rx      = {rx[6:0], spi_so};
            end
            #32;
            spi_sck  = mode3;
            spi_si   = ~spi_si;
            #32;
            spi_cs_n = 1'b1;
        end
    endtask
endmodule // sfcfe_master

// ==== tb/sfcfe_front_end_bench.sv ====
`timescale 1ns/1ps

module sfcfe_front_end_bench;
    import sfcfe_pkg::*;

    logic            core_clk;
    logic            rst_n;
    wire             spi_sck;
    wire             spi_cs_n;
    wire             spi_si;
    logic            spi_so;
    logic            spi_so_oe;
    sfcfe_state_type core_state;
    logic            core_frame_done;
    logic [7:0]      rx;
    int              errors;
    int              samples_checked;
    int              cycles;

    sfcfe_front_end uut (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .spi_sck         (spi_sck),
        .spi_cs_n        (spi_cs_n),
        .spi_si          (spi_si),
        .spi_so          (spi_so),
        .spi_so_oe       (spi_so_oe),
        .core_state      (core_state),
        .core_frame_done (core_frame_done)
    );

    sfcfe_master m (
        .spi_sck  (spi_sck),
        .spi_cs_n (spi_cs_n),
        .spi_si   (spi_si),
        .spi_so   (spi_so)
    );

    initial
    begin
        core_clk = 1'b0;
        rst_n    = 1'b0;
        errors   = 0;
        samples_checked = 0;
        cycles   = 0;
    end
    always #4 core_clk = ~core_clk;

    // ----------
    // Helpers
    // ----------
    task automatic close_out;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            close_out();
        end
    end

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic frame(input logic mode3, input logic [31:0] tx,
                         input int n);
        int k;
        logic seen;
        begin
            seen = 1'b0;
            m.xfer(mode3, tx, n, rx);
            for (k = 0; k < 20 && !seen; k++)
            begin
                @(posedge core_clk);
                #1;
                seen = (core_frame_done === 1'b1);
            end
            check(seen, "frame done missing");
        end
    endtask

    task automatic read_status(input logic [7:0] exp, input string msg);
        frame(1'b0, 32'h0000_0500, 2);
        check(rx === exp, msg);
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_latch;
        check(core_state === '0, "state after reset");
        read_status(8'h00, "status after reset");
        frame(1'b0, 32'h0000_0006, 1);
        read_status(8'h02, "latch not set");
        check(core_state.latch === 1'b1, "core latch");
        frame(1'b1, 32'h0000_0004, 1);
        read_status(8'h00, "latch not reset");
    endtask

    task automatic t_status_write;
        frame(1'b0, 32'h0000_0006, 1);
        frame(1'b1, 32'h0000_01FF, 2);
        read_status(8'h8C, "status write");
        frame(1'b0, 32'h0000_0100, 2);
        read_status(8'h8C, "write without latch");
        frame(1'b0, 32'h0000_0006, 1);
        frame(1'b0, 32'h0000_0100, 2);
        read_status(8'h00, "status clear");
    endtask

    task automatic t_invalid;
        logic [7:0] ops [4];
        int j;
        begin
            ops = '{8'hC3, 8'hC2, 8'h5A, 8'h5B};
            for (j = 0; j < 4; j++)
            begin
                frame(1'b0, {16'h0000, ops[j], 8'h06}, 2);
                read_status(8'h00, "bytes after invalid");
            end
        end
    endtask

    task automatic t_memory;
        frame(1'b0, 32'h0000_0006, 1);
        frame(1'b0, 32'h0280_05A5, 4);
        read_status(8'h00, "latch after write");
        frame(1'b1, 32'h0300_0500, 4);
        check(rx === 8'hA5, "read back");
        frame(1'b0, 32'h0200_055A, 4);
        frame(1'b0, 32'h0300_0500, 4);
        check(rx === 8'hA5, "write without latch");
    endtask

    initial
    begin
        repeat (16) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        t_latch();
        t_status_write();
        t_invalid();
        t_memory();
        close_out();
    end
endmodule // sfcfe_front_end_bench
